// ---- rtc_config_ram_lock.sv ----
// clock logical device configuration bank with ram lock over ahb-lite
//
// What this block does
// - activate bit 0 clear hides runtime access
// - standard base resets 00h/70h, bit0 zero
// - extended base resets 00h/72h, bit0 zero
// - interrupt number register resets to 08h
// - interrupt type: only bit 1 writable
// - both dma selects read fixed 04h
// - lock bits set by writing one
// - lock cleared by selected reset domain
// - unlock control clears all lock bits
// - bit 7 blocks standard 38h-3Fh
// - bit 6 blocks all ram writes
// - bit 5 blocks extended 00h-1Fh writes
// - bit 4 reads extended 00h-1Fh FFh
// - bit 3 blocks whole extended ram
// - day alarm offset bits 6-0
// - month alarm offset bits 6-0
// - century offset bits 6-0
// - lock bits 2-0 read zero
`timescale 1ns/100ps
module rtc_config_ram_lock (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic standby_resetn,
	input wire logic standby_lock_domain_select,
	input wire logic ram_unlock_all,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic runtime_enable,
	output logic [15:0] std_ram_base,
	output logic [15:0] ext_ram_base,
	output logic [7:0] irq_number_wake_enable,
	output logic [7:0] irq_type,
	output logic [6:0] day_alarm_register,
	output logic [6:0] month_alarm_register,
	output logic [6:0] hundred_year_register
);
	import rtc_cfg_pkg::*;

	// ****************************************
	// bus address phase capture
	// ****************************************
	cfg_req_type req_r;
	logic take;

	assign take = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_r <= '0;
		end else if (hready) begin
			req_r.valid <= take;
			req_r.write <= hwrite;
			req_r.index <= haddr[9:2];
			req_r.wdata <= 8'h00;
		end
	end

	logic wr;
	logic [7:0] wd;
	logic [7:0] idx;

	assign wr = req_r.valid && req_r.write;
	assign wd = hwdata[7:0];
	assign idx = req_r.index;

	// ****************************************
	// main power domain registers
	// ****************************************
	logic [7:0] activate_r;
	logic [7:0] std_hi_r;
	logic [7:0] std_lo_r;
	logic [7:0] ext_hi_r;
	logic [7:0] ext_lo_r;
	logic [7:0] irq_num_r;
	logic [7:0] irq_type_r;
	logic [7:0] side_ctrl_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			activate_r <= RST_ZERO;
			std_hi_r <= RST_ZERO;
			std_lo_r <= RST_STD_BASE_LO;
			ext_hi_r <= RST_ZERO;
			ext_lo_r <= RST_EXT_BASE_LO;
			irq_num_r <= RST_IRQ_NUM;
			irq_type_r <= RST_ZERO;
		end else if (wr) begin
			case (idx)
				IDX_ACTIVATE: activate_r <= wd;
				IDX_STD_BASE_HI: std_hi_r <= wd;
				IDX_STD_BASE_LO: std_lo_r <= wd & BASE_LO_MASK;
				IDX_EXT_BASE_HI: ext_hi_r <= wd;
				IDX_EXT_BASE_LO: ext_lo_r <= wd & BASE_LO_MASK;
				IDX_IRQ_NUM: irq_num_r <= wd;
				IDX_IRQ_TYPE: irq_type_r <= wd & IRQ_TYPE_MASK;
				default: begin
				end
			endcase
		end
	end

	// ram port control: bit 0 selects extended bank, bits 15-8 address
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			side_ctrl_r <= RST_ZERO;
		end else if (wr && idx == IDX_SIDE_CTRL) begin
			side_ctrl_r <= wd;
		end
	end

	logic [7:0] ram_addr_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ram_addr_r <= RST_ZERO;
		end else if (wr && idx == IDX_SIDE_CTRL) begin
			ram_addr_r <= hwdata[15:8];
		end
	end

	// ****************************************
	// standby domain offsets; locks on the selected reset domain
	// ****************************************
	logic [7:0] day_ofs_r;
	logic [7:0] month_ofs_r;
	logic [7:0] cent_ofs_r;

	always_ff @(posedge hclk or negedge standby_resetn) begin
		if (!standby_resetn) begin
			day_ofs_r <= RST_ZERO;
			month_ofs_r <= RST_ZERO;
			cent_ofs_r <= RST_ZERO;
		end else if (wr) begin
			case (idx)
				IDX_DAY_OFS: day_ofs_r <= wd & OFS_MASK;
				IDX_MONTH_OFS: month_ofs_r <= wd & OFS_MASK;
				IDX_CENT_OFS: cent_ofs_r <= wd & OFS_MASK;
				default: begin
				end
			endcase
		end
	end

	// lock clears on the domain chosen by the select input
	logic lock_rst_n;
	logic [7:0] lock_r;

	assign lock_rst_n = standby_lock_domain_select ? standby_resetn :
		hresetn;

	always_ff @(posedge hclk or negedge lock_rst_n) begin
		if (!lock_rst_n) begin
			lock_r <= RST_ZERO;
		end else if (ram_unlock_all) begin
			lock_r <= RST_ZERO;
		end else if (wr && idx == IDX_RAM_LOCK) begin
			lock_r <= lock_r | (wd & LOCK_MASK);
		end
	end

	lock_bits_type locks;

	assign locks.block_standard_high_bytes = lock_r[LK_STD_HIGH];
	assign locks.block_all_ram_writes = lock_r[LK_ALL_WR];
	assign locks.block_ext_low_writes = lock_r[LK_EXT_LOW_WR];
	assign locks.block_ext_low_reads = lock_r[LK_EXT_LOW_RD];
	assign locks.block_extended_ram = lock_r[LK_EXT_ALL];

	// ****************************************
	// ram access through the data port
	// ****************************************
	logic ext_sel;
	logic ram_wr_ok;
	logic [7:0] ram_raw;
	logic [7:0] ram_view;
	logic ram_hit;

	assign ext_sel = side_ctrl_r[0];
	assign ram_hit = idx == IDX_RAM_PORT && activate_r[ACTIVATE_BIT];

	ram_lock_filter u_filter (
		.locks(locks),
		.ext_sel(ext_sel),
		.ram_addr(ram_addr_r),
		.ram_rdata(ram_raw),
		.wr_allowed(ram_wr_ok),
		.rd_blocked(),
		.rd_value(ram_view)
	);

	rtc_ram_store u_store (
		.hclk(hclk),
		.ext_sel(ext_sel),
		.addr(ram_addr_r),
		.wr_en(wr && ram_hit && ram_wr_ok),
		.wdata(wd),
		.rdata(ram_raw)
	);

	// ****************************************
	// read mux
	// ****************************************
	logic [7:0] rd_byte;

	always_comb begin
		case (idx)
			IDX_ACTIVATE: rd_byte = activate_r;
			IDX_STD_BASE_HI: rd_byte = std_hi_r;
			IDX_STD_BASE_LO: rd_byte = std_lo_r;
			IDX_EXT_BASE_HI: rd_byte = ext_hi_r;
			IDX_EXT_BASE_LO: rd_byte = ext_lo_r;
			IDX_IRQ_NUM: rd_byte = irq_num_r;
			IDX_IRQ_TYPE: rd_byte = irq_type_r;
			IDX_DMA_SEL0: rd_byte = DMA_NONE;
			IDX_DMA_SEL1: rd_byte = DMA_NONE;
			IDX_RAM_LOCK: rd_byte = lock_r & LOCK_MASK;
			IDX_DAY_OFS: rd_byte = day_ofs_r;
			IDX_MONTH_OFS: rd_byte = month_ofs_r;
			IDX_CENT_OFS: rd_byte = cent_ofs_r;
			IDX_SIDE_CTRL: rd_byte = side_ctrl_r;
			IDX_RAM_PORT: rd_byte = ram_hit ? ram_view : BLOCKED_READ;
			default: rd_byte = RST_ZERO;
		endcase
	end

	assign hrdata = (req_r.valid && !req_r.write) ? {24'h000000, rd_byte} :
		32'h00000000;

	// ****************************************
	// configuration outputs
	// ****************************************
	assign runtime_enable = activate_r[ACTIVATE_BIT];
	assign std_ram_base = {std_hi_r, std_lo_r};
	assign ext_ram_base = {ext_hi_r, ext_lo_r};
	assign irq_number_wake_enable = irq_num_r;
	assign irq_type = irq_type_r;
	assign day_alarm_register = day_ofs_r[6:0];
	assign month_alarm_register = month_ofs_r[6:0];
	assign hundred_year_register = cent_ofs_r[6:0];
endmodule

// ---- rtc_cfg_pkg.sv ----
// package: register map, reset values and field layout of the clock config bank
package rtc_cfg_pkg;

	// ****************************************
	// register indices (byte address is four times the index)
	// ****************************************
	localparam logic [7:0] IDX_ACTIVATE = 8'h30;
	localparam logic [7:0] IDX_STD_BASE_HI = 8'h60;
	localparam logic [7:0] IDX_STD_BASE_LO = 8'h61;
	localparam logic [7:0] IDX_EXT_BASE_HI = 8'h62;
	localparam logic [7:0] IDX_EXT_BASE_LO = 8'h63;
	localparam logic [7:0] IDX_IRQ_NUM = 8'h70;
	localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
	localparam logic [7:0] IDX_DMA_SEL0 = 8'h74;
	localparam logic [7:0] IDX_DMA_SEL1 = 8'h75;
	localparam logic [7:0] IDX_RAM_LOCK = 8'hF0;
	localparam logic [7:0] IDX_DAY_OFS = 8'hF1;
	localparam logic [7:0] IDX_MONTH_OFS = 8'hF2;
	localparam logic [7:0] IDX_CENT_OFS = 8'hF3;
	localparam logic [7:0] IDX_SIDE_CTRL = 8'hF8;
	localparam logic [7:0] IDX_RAM_PORT = 8'hFC;

	// ****************************************
	// reset values and masks
	// ****************************************
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_STD_BASE_LO = 8'h70;
	localparam logic [7:0] RST_EXT_BASE_LO = 8'h72;
	localparam logic [7:0] RST_IRQ_NUM = 8'h08;
	localparam logic [7:0] DMA_NONE = 8'h04;
	localparam logic [7:0] BASE_LO_MASK = 8'hFE;
	localparam logic [7:0] IRQ_TYPE_MASK = 8'h02;
	localparam logic [7:0] LOCK_MASK = 8'hF8;
	localparam logic [7:0] OFS_MASK = 8'h7F;
	localparam logic [7:0] BLOCKED_READ = 8'hFF;
	localparam int ACTIVATE_BIT = 0;

	// ****************************************
	// lock bit positions
	// ****************************************
	localparam int LK_STD_HIGH = 7;
	localparam int LK_ALL_WR = 6;
	localparam int LK_EXT_LOW_WR = 5;
	localparam int LK_EXT_LOW_RD = 4;
	localparam int LK_EXT_ALL = 3;

	// ****************************************
	// ram geometry
	// ****************************************
	localparam logic [7:0] STD_HIGH_FIRST = 8'h38;
	localparam logic [7:0] STD_HIGH_LAST = 8'h3F;
	localparam logic [7:0] EXT_LOW_LAST = 8'h1F;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] index;
		logic [7:0] wdata;
	} cfg_req_type;

	typedef struct packed {
		logic block_standard_high_bytes;
		logic block_all_ram_writes;
		logic block_ext_low_writes;
		logic block_ext_low_reads;
		logic block_extended_ram;
	} lock_bits_type;

endpackage

// ---- ram_lock_filter.sv ----
// ram lock filter: gates ram accesses by the lock bits
`timescale 1ns/100ps
module ram_lock_filter (
	input wire rtc_cfg_pkg::lock_bits_type locks,
	input wire logic ext_sel,
	input wire logic [7:0] ram_addr,
	input wire logic [7:0] ram_rdata,
	output logic wr_allowed,
	output logic rd_blocked,
	output logic [7:0] rd_value
);
	import rtc_cfg_pkg::*;

	logic std_high;
	logic ext_low;

	assign std_high = !ext_sel && ram_addr >= STD_HIGH_FIRST &&
		ram_addr <= STD_HIGH_LAST;
	assign ext_low = ext_sel && ram_addr <= EXT_LOW_LAST;

	always_comb begin
		wr_allowed = 1'b1;
		rd_blocked = 1'b0;
		if (locks.block_standard_high_bytes && std_high) begin
			wr_allowed = 1'b0;
			rd_blocked = 1'b1;
		end
		if (locks.block_all_ram_writes) begin
			wr_allowed = 1'b0;
		end
		if (locks.block_ext_low_writes && ext_low) begin
			wr_allowed = 1'b0;
		end
		if (locks.block_ext_low_reads && ext_low) begin
			rd_blocked = 1'b1;
		end
		if (locks.block_extended_ram && ext_sel) begin
			wr_allowed = 1'b0;
			rd_blocked = 1'b1;
		end
	end

	assign rd_value = rd_blocked ? BLOCKED_READ : ram_rdata;
endmodule

// ---- rtc_ram_store.sv ----
// battery-backed ram array, standard and extended banks
`timescale 1ns/100ps
module rtc_ram_store #(
	parameter int DEPTH = 256
) (
	input wire logic hclk,
	input wire logic ext_sel,
	input wire logic [7:0] addr,
	input wire logic wr_en,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] std_mem [DEPTH];
	logic [7:0] ext_mem [DEPTH];

	always_ff @(posedge hclk) begin
		if (wr_en && !ext_sel) begin
			std_mem[addr] <= wdata;
		end
	end

	always_ff @(posedge hclk) begin
		if (wr_en && ext_sel) begin
			ext_mem[addr] <= wdata;
		end
	end

	assign rdata = ext_sel ? ext_mem[addr] : std_mem[addr];
endmodule

// ---- rtc_cfg_asserts.sv ----
// checker: bus and register relations of the clock config bank
`timescale 1ns/100ps
module rtc_cfg_asserts import rtc_cfg_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic standby_resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic runtime_enable,
	input wire logic [15:0] std_ram_base,
	input wire logic [15:0] ext_ram_base,
	input wire logic [7:0] irq_type,
	input wire logic [6:0] day_alarm_register
);
	logic dv, dw;
	logic [7:0] di;
	// ****
	// data phase tracking
	// ****
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dv <= 1'b0;
			dw <= 1'b0;
			di <= 8'h00;
		end else begin
			dv <= hsel && hready && htrans[1];
			dw <= hwrite;
			di <= haddr[9:2];
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn || !standby_resetn);
	sequence s_wr(logic [7:0] i);
		dv && dw && di == i;
	endsequence
	sequence s_rd(logic [7:0] i);
		dv && !dw && di == i;
	endsequence
	a_activate_write: assert property (s_wr(IDX_ACTIVATE) |=>
		runtime_enable == $past(hwdata[0])) else $error("activate");
	a_base_bit0: assert property (std_ram_base[0] == 1'b0 &&
		ext_ram_base[0] == 1'b0) else $error("base bit0");
	a_irq_type_ro: assert property ((irq_type & ~IRQ_TYPE_MASK) == 8'h00)
		else $error("irq type ro");
	a_irq_type_wr: assert property (s_wr(IDX_IRQ_TYPE) |=>
		irq_type[1] == $past(hwdata[1])) else $error("irq type wr");
	a_dma_fixed: assert property (dv && !dw &&
		(di == IDX_DMA_SEL0 || di == IDX_DMA_SEL1) |-> hrdata == 32'h4)
		else $error("dma select");
	a_lock_reserved: assert property (s_rd(IDX_RAM_LOCK) |->
		hrdata[2:0] == 3'h0) else $error("lock reserved");
	a_day_ofs_write: assert property (s_wr(IDX_DAY_OFS) |=>
		day_alarm_register == $past(hwdata[6:0])) else $error("day ofs");
	a_month_rsvd_bit: assert property (s_rd(IDX_MONTH_OFS) |->
		hrdata[7] == 1'b0) else $error("month ofs");
endmodule
bind rtc_config_ram_lock rtc_cfg_asserts u_rtc_cfg_asserts (.*);

// ---- tb_top.sv ----
// testbench: register and ram lock checks of the clock config bank
`timescale 1ns/100ps
module tb_top;
	import rtc_cfg_pkg::*;
	logic hclk, hresetn, standby_resetn, hsel, hwrite, hready, hresp;
	logic standby_lock_domain_select, ram_unlock_all, runtime_enable;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] std_ram_base, ext_ram_base;
	logic [7:0] irq_number_wake_enable, irq_type;
	logic [6:0] day_alarm_register, month_alarm_register;
	logic [6:0] hundred_year_register;
	int num_errors, samples_checked;
	rtc_config_ram_lock u_rtc_config_ram_lock (.*, .hreadyout(hready));
	// ****
	// tasks
	// ****
	task final_report;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task chk(string nm, logic [15:0] seen, logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s exp %h got %h", nm, exp, seen);
		end
	endtask
	task hold(output logic [7:0] q);
		logic r;
		r = 1'b0;
		for (int n = 0; n < 20 && !r; n++) begin
			@(posedge hclk);
			q = hrdata[7:0];
			r = (hready === 1'b1);
		end
		if (!r) begin
			num_errors++;
			final_report;
		end
	endtask
	task bus(logic w, logic [7:0] i, logic [15:0] d, output logic [7:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {22'h0, i, 2'b00};
		hwrite <= w;
		hold(q);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {16'h0, d};
		hold(q);
	endtask
	task wr(logic [7:0] i, logic [15:0] d);
		logic [7:0] q;
		bus(1'b1, i, d, q);
	endtask
	task rd(logic [7:0] i, logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, i, 16'h0, q);
		chk($sformatf("index %h", i), q, e);
	endtask
	task trw(logic [7:0] i, logic [7:0] r, logic [7:0] d, logic [7:0] e);
		rd(i, r);
		wr(i, {8'h00, d});
		rd(i, e);
	endtask
	task ram(logic b, logic [7:0] a, logic w, logic [7:0] d);
		wr(IDX_SIDE_CTRL, {a, 7'h00, b});
		if (w) begin
			wr(IDX_RAM_PORT, {8'h00, d});
		end else begin
			rd(IDX_RAM_PORT, d);
		end
	endtask
	task pulse(logic m);
		@(posedge hclk);
		if (m) begin
			hresetn <= 1'b0;
		end else begin
			standby_resetn <= 1'b0;
		end
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		standby_resetn <= 1'b1;
	endtask
	task unlock;
		@(posedge hclk);
		ram_unlock_all <= 1'b1;
		@(posedge hclk);
		ram_unlock_all <= 1'b0;
	endtask
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	// ****
	// main sequence
	// ****
	initial begin
		{num_errors, samples_checked} = 0;
		{hresetn, standby_resetn, ram_unlock_all, hsel, hwrite} = 5'h0;
		{haddr, hwdata, htrans} = 0;
		hsize = 3'b010;
		standby_lock_domain_select = 1'b1;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		standby_resetn <= 1'b1;
		trw(IDX_STD_BASE_HI, 8'h00, 8'hFF, 8'hFF);
		trw(IDX_STD_BASE_LO, 8'h70, 8'hFF, 8'hFE);
		trw(IDX_EXT_BASE_HI, 8'h00, 8'hFF, 8'hFF);
		trw(IDX_EXT_BASE_LO, 8'h72, 8'hFF, 8'hFE);
		trw(IDX_IRQ_NUM, 8'h08, 8'hFF, 8'hFF);
		trw(IDX_IRQ_TYPE, 8'h00, 8'hFF, 8'h02);
		trw(IDX_DMA_SEL0, 8'h04, 8'hFF, 8'h04);
		trw(IDX_DMA_SEL1, 8'h04, 8'h00, 8'h04);
		trw(IDX_DAY_OFS, 8'h00, 8'hFF, 8'h7F);
		trw(IDX_MONTH_OFS, 8'h00, 8'hD5, 8'h55);
		trw(IDX_CENT_OFS, 8'h00, 8'hAA, 8'h2A);
		trw(8'h40, 8'h00, 8'hFF, 8'h00);
		chk("std base", std_ram_base, 16'hFFFE);
		chk("ext base", ext_ram_base, 16'hFFFE);
		chk("century", {9'h0, hundred_year_register}, 16'h2A);
		chk("irq num", {8'h00, irq_number_wake_enable}, 16'h00FF);
		chk("irq type", {8'h00, irq_type}, 16'h0002);
		chk("day ofs", {9'h000, day_alarm_register}, 16'h007F);
		chk("month ofs", {9'h000, month_alarm_register}, 16'h0055);
		chk("resp", {15'h0000, hresp}, 16'h0000);
		trw(IDX_ACTIVATE, 8'h00, 8'h00, 8'h00);
		ram(1'b0, 8'h38, 1'b1, 8'h11);
		ram(1'b0, 8'h38, 1'b0, 8'hFF);
		trw(IDX_RAM_LOCK, 8'h00, 8'h07, 8'h00);
		wr(IDX_ACTIVATE, 16'h0001);
		@(negedge hclk);
		chk("runtime", {15'h0, runtime_enable}, 16'h1);
		ram(1'b0, 8'h38, 1'b1, 8'hA1);
		ram(1'b0, 8'h10, 1'b1, 8'hA2);
		ram(1'b1, 8'h00, 1'b1, 8'hA3);
		ram(1'b1, 8'h20, 1'b1, 8'hA4);
		ram(1'b0, 8'h38, 1'b0, 8'hA1);
		wr(IDX_RAM_LOCK, 16'h0080);
		ram(1'b0, 8'h38, 1'b1, 8'h55);
		ram(1'b0, 8'h38, 1'b0, 8'hFF);
		ram(1'b0, 8'h10, 1'b0, 8'hA2);
		wr(IDX_RAM_LOCK, 16'h0010);
		trw(IDX_RAM_LOCK, 8'h90, 8'h00, 8'h90);
		ram(1'b1, 8'h00, 1'b0, 8'hFF);
		ram(1'b1, 8'h20, 1'b0, 8'hA4);
		wr(IDX_RAM_LOCK, 16'h0020);
		ram(1'b1, 8'h00, 1'b1, 8'h66);
		ram(1'b1, 8'h20, 1'b1, 8'h67);
		unlock;
		rd(IDX_RAM_LOCK, 8'h00);
		ram(1'b0, 8'h38, 1'b0, 8'hA1);
		ram(1'b1, 8'h00, 1'b0, 8'hA3);
		ram(1'b1, 8'h20, 1'b0, 8'h67);
		wr(IDX_RAM_LOCK, 16'h0040);
		ram(1'b0, 8'h10, 1'b1, 8'h77);
		ram(1'b1, 8'h20, 1'b1, 8'h78);
		ram(1'b0, 8'h10, 1'b0, 8'hA2);
		wr(IDX_RAM_LOCK, 16'h0008);
		ram(1'b1, 8'h20, 1'b0, 8'hFF);
		unlock;
		wr(IDX_RAM_LOCK, 16'h0008);
		ram(1'b1, 8'h20, 1'b1, 8'h79);
		unlock;
		ram(1'b1, 8'h20, 1'b0, 8'h67);
		wr(IDX_RAM_LOCK, 16'h0080);
		pulse(1'b1);
		rd(IDX_RAM_LOCK, 8'h80);
		rd(IDX_CENT_OFS, 8'h2A);
		rd(IDX_ACTIVATE, 8'h00);
		rd(IDX_IRQ_NUM, 8'h08);
		rd(IDX_DAY_OFS, 8'h7F);
		chk("std base rst", std_ram_base, 16'h0070);
		pulse(1'b0);
		rd(IDX_RAM_LOCK, 8'h00);
		rd(IDX_CENT_OFS, 8'h00);
		standby_lock_domain_select <= 1'b0;
		wr(IDX_RAM_LOCK, 16'h0080);
		pulse(1'b0);
		rd(IDX_RAM_LOCK, 8'h80);
		pulse(1'b1);
		rd(IDX_RAM_LOCK, 8'h00);
		final_report;
	end
endmodule
